//--- tb/tb_txcs_top.sv
// self-checking bench of the transmit convergence sublayer
`timescale 1ns/1ps
`include "txcs_consts.svh"
module tb_txcs_top;
   import txcs_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic pclk, presetn, receive_active, link_fault;
   txcs_apb_req_type apb_req;
   txcs_mac_type mac;
   logic [31:0] prdata;
   logic pready, pslverr, nibble_next, transmitting, clash_flag;
   logic [4:0] code_group;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   logic armed = 1'b0;
   logic hunting = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] e;
   logic [4:0] enc_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   txcs_top dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mac(mac), .nibble_next(nibble_next),
      .transmitting(transmitting), .clash_flag(clash_flag),
      .receive_active(receive_active), .link_fault(link_fault), .code_group(code_group));
   txcs_mac_model mac_u (.pclk(pclk), .presetn(presetn), .nibble_next(nibble_next),
      .mac(mac));
   always #4 pclk = ~pclk;
   // ****************************************
   // tasks
   // ****************************************
   task tally_and_finish();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            input logic [31:0] ed, input logic ee);
      logic got, er;
      logic [31:0] d;
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      // registered outputs are steady at the falling edge before the sampling edge
      do begin
         @(negedge pclk);
         got = pready;
         d = prdata;
         er = pslverr;
         @(posedge pclk);
      end while (got !== 1'b1); // only the run timeout ends a hung wait
      apb_req <= '0;
      chk(got, 1'b1, "apb answer");
      chk(er, ee, "apb error");
      if (!wr) chk(d, ed, "apb read");
   endtask : apb
   task sym_wait(input int k);
      repeat (k) begin
         @(negedge pclk);
         while (nibble_next !== 1'b1) @(negedge pclk);
      end
   endtask : sym_wait
   task run_q();
      int n;
      n = 0;
      hunting = 1'b1;
      armed = 1'b1;
      while (armed && n < 600) begin
         @(posedge pclk);
         n++;
      end
      if (armed) chk(exp_q.size(), 0, "symbols missing");
      armed = 1'b0;
      exp_q.delete();
   endtask : run_q
   // entry: code, transmitting, clash, clash checked
   task send_frame(input int n, input logic ra, input logic rnd);
      logic [3:0] d;
      receive_active <= ra;
      mac_u.push(1'b1, 4'h5);
      mac_u.push(1'b1, 4'h5);
      exp_q.push_back({`TXCS_SYM_J, 1'b1, ra, 1'b1});
      exp_q.push_back({`TXCS_SYM_K, 1'b1, ra, 1'b1});
      for (int i = 0; i < n; i++) begin
         d = rnd ? 4'($urandom) : 4'(i);
         mac_u.push(1'b1, d);
         exp_q.push_back({enc_tab[d], 1'b1, ra, 1'b1});
      end
      mac_u.push(1'b0, 4'h0);
      exp_q.push_back({`TXCS_SYM_T, 1'b0, 1'b0, 1'b1});
      exp_q.push_back({`TXCS_SYM_R, 1'b0, 1'b0, 1'b1});
      exp_q.push_back({`TXCS_SYM_I, 1'b0, 1'b0, 1'b1});
      run_q();
      receive_active <= 1'b0;
   endtask : send_frame
   // ****************************************
   // result watcher
   // ****************************************
   always @(negedge pclk) begin
      if (armed && nibble_next === 1'b1 && !(hunting && code_group === `TXCS_SYM_I)) begin
         hunting = 1'b0;
         e = exp_q.pop_front();
         chk(code_group, e[7:3], "code group");
         chk(transmitting, e[2], "transmitting");
         if (e[0]) chk(clash_flag, e[1], "clash flag");
         if (exp_q.size() == 0) armed = 1'b0;
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         $display("unexpected at %0t: run too long", $time);
         tally_and_finish();
      end
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      apb_req = '0;
      receive_active = 1'b0;
      link_fault = 1'b0;
      void'($urandom(74));
      repeat (5) @(posedge pclk);
      #1 chk(code_group, `TXCS_SYM_I, "reset symbol");
      chk({transmitting, clash_flag, pready, nibble_next}, 0, "reset flags");
      repeat (7) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `TXCS_OFF_STATUS, 0, 0, 1'b0);
      send_frame(16, 1'b0, 1'b0);
      send_frame(20, 1'b1, 1'b1);
      // request dropped during the start delimiter
      mac_u.push(1'b1, 4'h5);
      mac_u.push(1'b0, 4'h0);
      exp_q.push_back({`TXCS_SYM_J, 1'b1, 1'b0, 1'b1});
      exp_q.push_back({`TXCS_SYM_I, 1'b0, 1'b0, 1'b1});
      run_q();
      // link fault in mid payload, request still high
      mac_u.push(1'b1, 4'h5);
      mac_u.push(1'b1, 4'h5);
      repeat (30) mac_u.push(1'b1, 4'hA);
      sym_wait(6);
      @(posedge pclk);
      link_fault <= 1'b1;
      @(posedge pclk);
      @(negedge pclk);
      chk({code_group, transmitting}, {`TXCS_SYM_I, 1'b0}, "fault abort");
      repeat (12) @(posedge pclk);
      #1 chk(code_group, `TXCS_SYM_I, "fault holds idle");
      mac_u.flush();
      sym_wait(2);
      @(posedge pclk);
      link_fault <= 1'b0;
      // raw symbol mode sends an invalid code unencoded
      apb(1'b1, `TXCS_OFF_CTRL, 32'h00000301, 0, 1'b0);
      apb(1'b0, `TXCS_OFF_CTRL, 0, 32'h00000301, 1'b0);
      sym_wait(3);
      chk(code_group, 5'h03, "raw symbol");
      apb(1'b0, `TXCS_OFF_STATUS, 0, 32'h00000008, 1'b0);
      apb(1'b1, `TXCS_OFF_CTRL, 0, 0, 1'b0);
      sym_wait(3);
      chk(code_group, `TXCS_SYM_I, "raw left");
      // only the two whole frames count
      apb(1'b0, `TXCS_OFF_FRAMES, 0, 32'h00000002, 1'b0);
      apb(1'b1, `TXCS_OFF_STATUS, 32'h000000FF, 0, 1'b0);
      apb(1'b0, `TXCS_OFF_STATUS, 0, 0, 1'b0);
      apb(1'b1, 12'h00C, 32'hFFFFFFFF, 0, 1'b1);
      apb(1'b0, 12'h00C, 0, 0, 1'b1);
      tally_and_finish();
   end
endmodule : tb_txcs_top

//--- tb/txcs_mac_model.sv
// mac partner model feeding frame request and nibbles
`timescale 1ns/1ps
module txcs_mac_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // symbol pacing
   input wire logic nibble_next,
   // mac output
   output txcs_pkg::txcs_mac_type mac
);
   import txcs_pkg::*;
   txcs_mac_type items[$];
   logic seen;
   task push(input logic req, input logic [3:0] nib);
      items.push_back('{req, nib});
   endtask : push
   task flush();
      items.delete();
   endtask : flush
   // pulse caught mid-cycle, away from the edge that moves it
   always @(negedge pclk) begin
      seen = nibble_next;
   end
   // one item per symbol, changed just after the pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mac <= '0;
      end else if (seen === 1'b1) begin
         if (items.size() > 0) begin
            mac <= items.pop_front(); // request comes with first preamble nibble
         end else begin
            // released nibble toggles so a stale value never looks valid
            mac <= '{1'b0, ~mac.outbound_nibble};
         end
      end
   end
endmodule : txcs_mac_model

//--- verilog/txcs_consts.svh
// constants of the transmit convergence sublayer
`ifndef TXCS_CONSTS_SVH
`define TXCS_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define TXCS_CLK_PERIOD_NS 8
`define TXCS_SYM_PERIOD_NS 40
`define TXCS_SYM_CYCLES (`TXCS_SYM_PERIOD_NS / `TXCS_CLK_PERIOD_NS)
`define TXCS_DIV_W 3
`define TXCS_DIV_ZERO 3'h0

// ****************************************
// code groups
// ****************************************
`define TXCS_SYM_W 5
`define TXCS_SYM_ZERO 5'h00
`define TXCS_SYM_I 5'h1F
`define TXCS_SYM_J 5'h18
`define TXCS_SYM_K 5'h11
`define TXCS_SYM_T 5'h0D
`define TXCS_SYM_R 5'h07

// ****************************************
// state codes, binary
// ****************************************
`define TXCS_ST_IDLE 4'h0
`define TXCS_ST_J 4'h1
`define TXCS_ST_K 4'h2
`define TXCS_ST_TX 4'h3
`define TXCS_ST_T 4'h4
`define TXCS_ST_R 4'h5
`define TXCS_ST_TEST 4'h8

// ****************************************
// register map
// ****************************************
`define TXCS_ADDR_W 12
`define TXCS_OFF_CTRL 12'h000
`define TXCS_OFF_STATUS 12'h004
`define TXCS_OFF_FRAMES 12'h008
`define TXCS_WORD_ZERO 32'h00000000
`define TXCS_FRAMES_ONE 32'h00000001

`endif

//--- verilog/txcs_encoder.sv
// registered 4b5b data encoder
`timescale 1ns/1ps
module txcs_encoder (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // data
   input wire logic [3:0] nibble,
   output logic [4:0] code_q
);
`include "txcs_consts.svh"

   logic [4:0] code_nxt;
   logic [4:0] code_r;

   // two logic levels per bit; bit0 passes straight through [R1] [R2]
   always_comb begin
      code_nxt[4] = nibble[3] | (~nibble[2] & nibble[1]) | (~nibble[2] & ~nibble[0]);
      code_nxt[3] = nibble[2] | (~nibble[3] & ~nibble[1]);
      code_nxt[2] = nibble[1] | (~nibble[3] & ~nibble[2] & ~nibble[0]);
      code_nxt[1] = (~nibble[1] & ~nibble[0]) | (nibble[3] ^ nibble[2]) | (nibble[2] & ~nibble[1]);
      code_nxt[0] = nibble[0];
   end

   // cleared in reset, loaded every clock [R3]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_r <= `TXCS_SYM_ZERO;
      end else begin
         code_r <= code_nxt;
      end
   end

   assign code_q = code_r;

endmodule : txcs_encoder

//--- verilog/txcs_pkg.sv
// types of the transmit convergence sublayer
package txcs_pkg;
`include "txcs_consts.svh"

   typedef enum logic [3:0] {
      ST_IDLE = `TXCS_ST_IDLE,
      ST_J = `TXCS_ST_J,
      ST_K = `TXCS_ST_K,
      ST_TX = `TXCS_ST_TX,
      ST_T = `TXCS_ST_T,
      ST_R = `TXCS_ST_R,
      ST_TEST = `TXCS_ST_TEST
   } txcs_state_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`TXCS_ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } txcs_apb_req_type;

   typedef struct packed {
      logic frame_request;
      logic [3:0] outbound_nibble;
   } txcs_mac_type;

   typedef struct packed {
      logic [18:0] pad_hi;
      logic [4:0] raw_symbol;
      logic [6:0] pad_lo;
      logic raw_symbol_mode;
   } txcs_ctrl_type;

   typedef struct packed {
      logic [23:0] pad;
      logic link_fault;
      logic frame_request_flag;
      logic clash_flag;
      logic transmitting;
      logic [3:0] state;
   } txcs_status_type;

endpackage : txcs_pkg

//--- verilog/txcs_top.sv
// transmit convergence sublayer: symbol sequencer, encoder path, apb registers
//
// How it works
// R1 - each payload nibble from the mac becomes one five-bit code group
// R2 - encoder bits follow the fixed boolean equations, bit0 copies data bit0
// R3 - encoder output is registered and cleared while reset is low
// R4 - idle keeps transmitting and clash low and sends idle every symbol
// R5 - mac raises frame request; device enters start and asserts transmitting
// R6 - in start and transmit the clash flag follows receive active
// R7 - first two preamble nibbles are replaced by code groups j then k
// R8 - frame request falling during the start delimiter returns to idle
// R9 - transmit encodes nibbles until frame request falls, then goes to end
// R10 - end clears flags, sends t then r, then returns to idle
// R11 - link fault forces idle at once from any state, beating any request
// R12 - transitions are judged only at symbol ends, except on link fault; states hold otherwise
// R13 - raw symbol mode entered from idle sends supplied code groups unencoded
// R14 - state is four binary flip-flops steering the symbol mux directly
// R15 - mac nibbles are aligned to the symbol clock before being sent
// R16 - one code group per symbol period in every state, no gaps, except the symbol that a link fault cuts short by forcing idle at once
// R17 - idle code group is 11111
// R18 - start delimiter is j 11000 followed by k 10001
// R19 - end delimiter is t 01101 followed by r 00111
// R20 - mac delivers four-bit nibbles at the 25 mhz symbol rate
`timescale 1ns/1ps
module txcs_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire txcs_pkg::txcs_apb_req_type apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // mac side
   input wire txcs_pkg::txcs_mac_type mac,
   output logic nibble_next,
   output logic transmitting,
   output logic clash_flag,
   // receive and link monitor
   input wire logic receive_active,
   input wire logic link_fault,
   // media side
   output logic [4:0] code_group
);
   import txcs_pkg::*;
`include "txcs_consts.svh"

   localparam logic [`TXCS_DIV_W-1:0] DIV_LAST = `TXCS_DIV_W'(`TXCS_SYM_CYCLES - 1);

   // ****************************************
   // symbol timing
   // ****************************************
   logic [`TXCS_DIV_W-1:0] div_r;
   logic [`TXCS_DIV_W-1:0] div_nxt;
   logic sym_tick;
   logic nibble_next_r;
   logic nibble_next_nxt;

   // fixed divide keeps one code group per symbol period [R16]
   always_comb begin
      sym_tick = (div_r == DIV_LAST);
      div_nxt = sym_tick ? `TXCS_DIV_ZERO : div_r + 1'b1;
      nibble_next_nxt = sym_tick; // mac steps its nibble on this beat [R15] [R20]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= `TXCS_DIV_ZERO;
         nibble_next_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         nibble_next_r <= nibble_next_nxt;
      end
   end

   // ****************************************
   // encoder
   // ****************************************
   logic [4:0] enc_code;

   // one cycle of latency; the mac holds its nibble for the whole symbol [R3]
   txcs_encoder u_enc (
      .pclk(pclk),
      .presetn(presetn),
      .nibble(mac.outbound_nibble),
      .code_q(enc_code)
   );

   // ****************************************
   // control registers
   // ****************************************
   txcs_ctrl_type ctrl_r;
   txcs_ctrl_type ctrl_nxt;
   logic [31:0] frames_r;
   logic [31:0] frames_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   txcs_status_type status;
   logic setup;
   logic wr_en;
   logic addr_ok;

   // ****************************************
   // sequencer
   // ****************************************
   txcs_state_type state_r;
   txcs_state_type state_nxt;
   logic [4:0] code_group_r;
   logic [4:0] code_group_nxt;
   logic transmitting_r;
   logic transmitting_nxt;
   logic clash_r;
   logic clash_nxt;
   logic in_frame_nxt;

   always_comb begin
      state_nxt = state_r;
      code_group_nxt = code_group_r;
      frames_nxt = frames_r;
      // actions take a whole symbol; leave a state only at its end, unless link fault forces idle [R12]
      if (sym_tick) begin
         case (state_r)
            ST_IDLE: begin
               if (ctrl_r.raw_symbol_mode) begin
                  state_nxt = ST_TEST; // [R13]
               end else if (mac.frame_request) begin
                  state_nxt = ST_J; // [R5]
               end
            end
            ST_J: begin
               state_nxt = mac.frame_request ? ST_K : ST_IDLE; // [R8]
            end
            ST_K: begin
               state_nxt = mac.frame_request ? ST_TX : ST_IDLE; // [R8]
            end
            ST_TX: begin
               state_nxt = mac.frame_request ? ST_TX : ST_T; // [R9]
            end
            ST_T: begin
               state_nxt = ST_R; // [R10]
            end
            ST_R: begin
               state_nxt = ST_IDLE; // [R10]
               frames_nxt = frames_r + `TXCS_FRAMES_ONE;
            end
            ST_TEST: begin
               state_nxt = ctrl_r.raw_symbol_mode ? ST_TEST : ST_IDLE; // [R13]
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
         // state bits pick the mux source with no extra decode [R14]
         case (state_nxt)
            ST_J: code_group_nxt = `TXCS_SYM_J; // [R7] [R18]
            ST_K: code_group_nxt = `TXCS_SYM_K; // [R7] [R18]
            ST_TX: code_group_nxt = enc_code; // [R1] [R9]
            ST_T: code_group_nxt = `TXCS_SYM_T; // [R19]
            ST_R: code_group_nxt = `TXCS_SYM_R; // [R19]
            ST_TEST: code_group_nxt = ctrl_r.raw_symbol; // bypasses the encoder [R13]
            default: code_group_nxt = `TXCS_SYM_I; // [R4] [R17]
         endcase
      end
      // fault does not wait for the symbol end; the line goes idle now [R11]
      if (link_fault) begin
         state_nxt = ST_IDLE;
         code_group_nxt = `TXCS_SYM_I;
         frames_nxt = frames_r;
      end
      in_frame_nxt = (state_nxt == ST_J) || (state_nxt == ST_K) || (state_nxt == ST_TX);
      transmitting_nxt = in_frame_nxt; // [R4] [R5] [R10]
      clash_nxt = in_frame_nxt & receive_active; // [R6] [R10]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         code_group_r <= `TXCS_SYM_I;
         transmitting_r <= 1'b0;
         clash_r <= 1'b0;
         frames_r <= `TXCS_WORD_ZERO;
      end else begin
         state_r <= state_nxt;
         code_group_r <= code_group_nxt;
         transmitting_r <= transmitting_nxt;
         clash_r <= clash_nxt;
         frames_r <= frames_nxt;
      end
   end

   // ****************************************
   // apb slave
   // ****************************************
   // zero wait states: data is fetched in setup, ready stands in access
   always_comb begin
      setup = apb_req.psel & ~apb_req.penable;
      wr_en = apb_req.psel & apb_req.penable & pready_r & apb_req.pwrite;
      addr_ok = (apb_req.paddr == `TXCS_OFF_CTRL) || (apb_req.paddr == `TXCS_OFF_STATUS) ||
         (apb_req.paddr == `TXCS_OFF_FRAMES);
      status = '0;
      status.link_fault = link_fault;
      status.frame_request_flag = mac.frame_request;
      status.clash_flag = clash_r;
      status.transmitting = transmitting_r;
      status.state = state_r;
      ctrl_nxt = ctrl_r;
      if (wr_en && !pslverr_r && (apb_req.paddr == `TXCS_OFF_CTRL)) begin
         ctrl_nxt = apb_req.pwdata;
         ctrl_nxt.pad_hi = '0;
         ctrl_nxt.pad_lo = '0;
      end
      pready_nxt = setup;
      pslverr_nxt = setup & ~addr_ok;
      prdata_nxt = `TXCS_WORD_ZERO;
      if (setup && !apb_req.pwrite) begin
         case (apb_req.paddr)
            `TXCS_OFF_CTRL: prdata_nxt = ctrl_r;
            `TXCS_OFF_STATUS: prdata_nxt = status;
            `TXCS_OFF_FRAMES: prdata_nxt = frames_r;
            default: prdata_nxt = `TXCS_WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= '0;
         prdata_r <= `TXCS_WORD_ZERO;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign nibble_next = nibble_next_r;
   assign transmitting = transmitting_r;
   assign clash_flag = clash_r;
   assign code_group = code_group_r;

   // ****************************************
   // checks
   // ****************************************
   // independent table, not the encoder equations
   function automatic logic [4:0] ref_code(input logic [3:0] n);
      logic [4:0] c;
      c = 5'h00;
      case (n)
         4'h0: c = 5'h1E;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0A;
         4'h5: c = 5'h0B;
         4'h6: c = 5'h0E;
         4'h7: c = 5'h0F;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'hA: c = 5'h16;
         4'hB: c = 5'h17;
         4'hC: c = 5'h1A;
         4'hD: c = 5'h1B;
         4'hE: c = 5'h1C;
         default: c = 5'h1D;
      endcase
      return c;
   endfunction : ref_code

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_idle_quiet: assert property ((state_r == ST_IDLE) |->  // [R4] [R17]
      (!transmitting_r && !clash_r && code_group_r == `TXCS_SYM_I))
      else $error("idle state not quiet");
   a_symbol_rate: assert property (sym_tick |=> (!sym_tick)[*4] ##1 sym_tick) // [R16]
      else $error("symbol period is not five clocks");
   a_encode_map: assert property ((sym_tick && state_nxt == ST_TX) |=>  // [R1] [R2] [R9]
      (code_group_r == ref_code($past(mac.outbound_nibble, 2))))
      else $error("payload code group wrong");
   a_start_pair: assert property ($rose(state_r == ST_J) |->  // [R5] [R7] [R18]
      (code_group_r == `TXCS_SYM_J && transmitting_r) ##5
      (code_group_r == `TXCS_SYM_K || state_r == ST_IDLE))
      else $error("start delimiter wrong");
   a_start_drop: assert property ((sym_tick && (state_r == ST_J || state_r == ST_K) &&  // [R8]
      !mac.frame_request) |=> (state_r == ST_IDLE))
      else $error("dropped request did not return to idle");
   a_end_pair: assert property ((sym_tick && state_r == ST_TX && !mac.frame_request &&  // [R10]
      !link_fault) |=> (code_group_r == `TXCS_SYM_T && !transmitting_r) ##5
      (code_group_r == `TXCS_SYM_R || state_r == ST_IDLE))
      else $error("end delimiter wrong");
   a_clash_follow: assert property (in_frame_nxt |=> (clash_r == $past(receive_active))) // [R6]
      else $error("clash flag does not follow receive");
   a_fault_idle: assert property (link_fault |=> (state_r == ST_IDLE)) // [R11]
      else $error("link fault did not force idle");
   a_raw_symbol: assert property ((sym_tick && state_nxt == ST_TEST) |=>  // [R13]
      (code_group_r == $past(ctrl_r.raw_symbol)))
      else $error("raw symbol not sent");
   a_hold_state: assert property ((!sym_tick && !link_fault) |=> $stable(state_r)) // [R12] [R14]
      else $error("state moved inside a symbol");
   a_apb_ready: assert property (setup |=> (pready_r ##1 !pready_r))
      else $error("apb answer not one cycle");

   c_full_frame: cover property ((state_r == ST_R) ##1 (state_r == ST_IDLE));
   c_start_drop: cover property ((state_r == ST_K) ##1 (state_r == ST_IDLE));
   c_raw_mode: cover property (state_r == ST_TEST);
   c_fault_tx: cover property ((state_r == ST_TX) && link_fault);

endmodule : txcs_top
